// file: rtl/sxp_pkg.sv
package sxp_pkg;
  // Bus widths and unit counts.
  localparam int ADDR_W = 32;
  localparam int DATA_W = 64;
  localparam int WORD_W = 32;
  localparam int INSTR_W = 48;
  localparam int NUM_PEERS = 6;
  localparam int NUM_BANKS = 4;
  localparam int BANK_SEL_W = 2;
  localparam int NUM_DMA = 4;
  localparam int NUM_EXT_DMA = 2;
  localparam int WAIT_W = 4;
  localparam int PACK_W = 2;
  localparam int OWN_AREA_W = 20;
  localparam int ID_W = 3;
  // Packing codes, in halfwords per packed word minus one.
  localparam logic [1:0] PACK_16 = 2'h0;
  localparam logic [1:0] PACK_32 = 2'h1;
  localparam logic [1:0] PACK_48 = 2'h2;
  localparam logic [1:0] PACK_64 = 2'h3;
  // Processor ids on the shared bus; zero belongs to no peer.
  localparam logic [2:0] ID_NONE = 3'h0;
  localparam logic [2:0] ID_BCAST = 3'h7;
  // Access types.
  typedef enum logic [1:0] {
    SXP_ASYNC,
    SXP_SYNC,
    SXP_BURST
  } sxp_acc_e;
  // One request from an internal bus (program, data or I/O).
  typedef struct packed {
    logic valid;
    logic write;
    logic fetch;
    logic pair;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } sxp_req_s;
  // External bus drive toward pins.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [1:0] lane_en;
    logic rd_n;
    logic wr_n;
    logic ras_n;
    logic cas_n;
  } sxp_ext_s;
endpackage : sxp_pkg

// file: rtl/sxp_port.sv
// Notes on behaviour
// - Three internal buses merge onto one external bus.
// - Even word uses low half, odd high.
// - Address picks one word; pair transfers two.
// - Fetch reads pair, drops top sixteen bits.
// - Asynchronous, single synchronous and burst accesses.
// - High address bits decode to bank selects.
// - Row and column strobes for page DRAM.
// - Programmed waits plus acknowledge stretching.
// - Four gigaword external space in unified map.
// - Peers may access our internal memory.
// - Arbitration among six processors, us included, plus host.
// - Mastership handover costs one cycle.
// - Fixed or rotating priority selectable.
// - Bus lock bars the host grant for RMW.
// - Peers raise a vector interrupt command.
// - Broadcast write reaches every processor.
// - DMA packs into 16/32/48/64-bit words.
// - Two request/grant pairs pace external DMA.
// - Four DMA channels serve the port.
// - Port runs at the input clock rate.
// - Host requests bus, waits grant, then accesses.
`timescale 1ns/1ps
`default_nettype none
module sxp_port #(
  parameter int PEERS = sxp_pkg::NUM_PEERS,
  parameter int BANKS = sxp_pkg::NUM_BANKS
) (
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire sxp_pkg::sxp_req_s PM_REQ,
  input wire sxp_pkg::sxp_req_s DM_REQ,
  input wire sxp_pkg::sxp_req_s IO_REQ,
  input wire logic [1:0] ACC_TYPE,
  input wire logic [sxp_pkg::WAIT_W-1:0] WAIT_STATES,
  input wire logic [sxp_pkg::BANK_SEL_W-1:0] BANK_SHIFT,
  input wire logic [sxp_pkg::ID_W-1:0] MY_ID,
  input wire logic ROTATE_EN,
  input wire logic LOCK_REQ,
  input wire logic [PEERS-1:0] PEER_BUS_REQ,
  input wire logic HOST_BUS_REQUEST,
  input wire logic HOST_CS,
  input wire logic ACK_IN,
  input wire logic [sxp_pkg::DATA_W-1:0] EXT_DATA_IN,
  input wire logic [sxp_pkg::ADDR_W-1:0] SLV_ADDR,
  input wire logic SLV_WRITE,
  input wire logic SLV_STROBE,
  input wire logic [sxp_pkg::NUM_EXT_DMA-1:0] EXT_DMA_REQUEST,
  input wire logic [sxp_pkg::NUM_DMA-1:0] DMA_EN,
  input wire logic [sxp_pkg::PACK_W-1:0] PACK_MODE,
  output logic [2:0] REQ_DONE,
  output logic [sxp_pkg::DATA_W-1:0] RDATA,
  output logic [sxp_pkg::INSTR_W-1:0] INSTR,
  output sxp_pkg::sxp_ext_s EXT_OUT,
  output logic EXT_DATA_OE,
  output logic EXT_ADDR_OE,
  output logic [BANKS-1:0] BANK_SEL_N,
  output logic BUS_REQ_OUT,
  output logic BUS_OWNED,
  output logic HOST_BUS_GRANT,
  output logic HOST_ACCESS_READY,
  output logic INT_MEM_SEL,
  output logic VIRQ,
  output logic BCAST_SEL,
  output logic [sxp_pkg::NUM_EXT_DMA-1:0] EXT_DMA_GRANT,
  output logic [sxp_pkg::NUM_DMA-1:0] DMA_SERVED,
  output logic [sxp_pkg::DATA_W-1:0] DMA_WORD,
  output logic DMA_WORD_VALID
);
  import sxp_pkg::*;

  // The elaboration check refuses shapes the arbiter cannot serve.
  if (PEERS < 1 || PEERS > NUM_PEERS || BANKS != NUM_BANKS) begin : g_chk
    $error("sxp_port: unsupported PEERS or BANKS");
  end

  typedef enum {ST_IDLE, ST_ARB, ST_ADDR, ST_WAIT, ST_DONE} sxp_st_e;
  sxp_st_e st_q;
  sxp_req_s cur_q;
  logic [1:0] src_q;
  logic [WAIT_W-1:0] wcnt_q;
  logic [ID_W-1:0] rot_q;
  logic lock_q;
  logic host_gnt_q;
  logic peer_win;
  logic [1:0] pick;
  logic any_req;
  logic acc_go;
  logic peer_any;
  logic [DATA_W-1:0] pack_q;
  logic [1:0] pcnt_q;
  logic [1:0] dsel_q;
  logic [NUM_EXT_DMA-1:0] gnt_q;

  // Internal source pick: data before program before I/O.
  always_comb begin
    any_req = PM_REQ.valid | DM_REQ.valid | IO_REQ.valid;
    if (DM_REQ.valid) begin
      pick = 2'h1;
    end else if (PM_REQ.valid) begin
      pick = 2'h0;
    end else begin
      pick = 2'h2;
    end
  end

  // A peer wins over us if it has higher priority than our id.
  always_comb begin
    peer_win = 1'b0;
    peer_any = |PEER_BUS_REQ;
    for (int i = 0; i < PEERS; i++) begin
      if (PEER_BUS_REQ[i] && (i + 1) != int'(MY_ID)) begin
        // Fixed: lower id wins. Rotating: rot_q wins first, then the ids after it.
        if (!ROTATE_EN && (i + 1) < int'(MY_ID)) begin
          peer_win = 1'b1;
        end
        if (ROTATE_EN && ((3'(i + 1) - rot_q) < (MY_ID - rot_q))) begin
          peer_win = 1'b1;
        end
      end
    end
  end

  // We may start when the host holds no grant and no peer outranks us.
  assign acc_go = (st_q == ST_ARB) && !peer_win && !host_gnt_q;

  // Main access sequencer, stepped once per port clock.
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      st_q <= ST_IDLE;
      cur_q <= '0;
      src_q <= 2'h0;
      wcnt_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (any_req) begin
            src_q <= pick;
            cur_q <= (pick == 2'h1) ? DM_REQ : (pick == 2'h0) ? PM_REQ : IO_REQ;
            st_q <= ST_ARB;
          end
        end
        ST_ARB: begin
          // Handover: one idle cycle between masters.
          if (acc_go) begin
            st_q <= ST_ADDR;
            wcnt_q <= WAIT_STATES;
          end
        end
        ST_ADDR: begin
          st_q <= ST_WAIT;
        end
        ST_WAIT: begin
          // Wait states count down, then acknowledge may still stretch.
          if (wcnt_q != '0) begin
            wcnt_q <= wcnt_q - 1'b1;
          end else if (ACK_IN || ACC_TYPE != 2'(SXP_ASYNC)) begin
            st_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          // Burst read keeps the bus while the same source is still the one picked.
          if (ACC_TYPE == 2'(SXP_BURST) && !cur_q.write && any_req
              && pick == src_q) begin
            cur_q <= (pick == 2'h1) ? DM_REQ : (pick == 2'h0) ? PM_REQ : IO_REQ;
            cur_q.addr <= cur_q.addr + (cur_q.pair ? 32'h2 : 32'h1);
            st_q <= ST_WAIT;
            wcnt_q <= WAIT_W'(1); // New address reaches the pins first.
          end else begin
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Rotating priority pointer is set to our id after each of our own accesses.
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      rot_q <= ID_NONE;
    end else if (st_q == ST_DONE) begin
      rot_q <= MY_ID;
    end
  end

  // Lock is taken while we own the bus and dropped only by its owner.
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      lock_q <= 1'b0;
    end else if (!LOCK_REQ) begin
      lock_q <= 1'b0;
    end else if (BUS_OWNED) begin
      lock_q <= 1'b1;
    end
  end

  // Host grant only when we are idle or arbitrating and not locked.
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      host_gnt_q <= 1'b0;
    end else if (!HOST_BUS_REQUEST) begin
      host_gnt_q <= 1'b0;
    end else if (!lock_q && st_q inside {ST_IDLE, ST_ARB}) begin
      host_gnt_q <= 1'b1;
    end
  end

  // External bus drive and lane steering.
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      EXT_OUT <= '{rd_n: 1'b1, wr_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
                   default: '0};
    end else begin
      EXT_OUT.addr <= cur_q.addr;
      // Even words go on the low half, odd on the high half.
      if (cur_q.pair || cur_q.fetch) begin
        EXT_OUT.lane_en <= 2'h3;
        EXT_OUT.data <= cur_q.wdata;
      end else if (cur_q.addr[0]) begin
        EXT_OUT.lane_en <= 2'h2;
        EXT_OUT.data <= {cur_q.wdata[WORD_W-1:0], 32'h0};
      end else begin
        EXT_OUT.lane_en <= 2'h1;
        EXT_OUT.data <= {32'h0, cur_q.wdata[WORD_W-1:0]};
      end
      EXT_OUT.rd_n <= !(BUS_OWNED && !cur_q.write);
      EXT_OUT.wr_n <= !(BUS_OWNED && cur_q.write);
      // Row strobe held over the access, column strobe in the data phase.
      EXT_OUT.ras_n <= !(st_q inside {ST_ADDR, ST_WAIT, ST_DONE});
      EXT_OUT.cas_n <= !(st_q == ST_WAIT);
    end
  end

  assign BUS_OWNED = st_q inside {ST_ADDR, ST_WAIT, ST_DONE};
  assign BUS_REQ_OUT = st_q != ST_IDLE;
  assign EXT_ADDR_OE = BUS_OWNED;
  assign EXT_DATA_OE = BUS_OWNED && cur_q.write;
  assign HOST_BUS_GRANT = host_gnt_q;
  assign HOST_ACCESS_READY = SLV_STROBE && HOST_CS;

  // Bank selects from the top address bits, shifted by size setting.
  always_comb begin
    logic [1:0] bank;
    bank = cur_q.addr[ADDR_W-1 -: 2] >> BANK_SHIFT;
    BANK_SEL_N = '1;
    if (BUS_OWNED) begin
      BANK_SEL_N[bank] = 1'b0;
    end
  end

  // Read return to the requesting internal bus.
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      REQ_DONE <= 3'h0;
      RDATA <= '0;
      INSTR <= '0;
    end else begin
      REQ_DONE <= 3'h0;
      if (st_q == ST_WAIT && wcnt_q == '0
          && (ACK_IN || ACC_TYPE != 2'(SXP_ASYNC))) begin
        REQ_DONE[src_q] <= 1'b1;
        RDATA <= cur_q.addr[0] && !cur_q.pair
                 ? {32'h0, EXT_DATA_IN[DATA_W-1:WORD_W]} : EXT_DATA_IN;
        INSTR <= EXT_DATA_IN[INSTR_W-1:0];
      end
    end
  end

  // Slave decode: own area, broadcast and vector interrupt.
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      INT_MEM_SEL <= 1'b0;
      BCAST_SEL <= 1'b0;
      VIRQ <= 1'b0;
    end else begin
      INT_MEM_SEL <= SLV_STROBE && (SLV_ADDR[OWN_AREA_W+:ID_W] == MY_ID
                     || HOST_CS);
      BCAST_SEL <= SLV_STROBE && SLV_WRITE
                   && SLV_ADDR[OWN_AREA_W+:ID_W] == ID_BCAST;
      VIRQ <= SLV_STROBE && SLV_WRITE && SLV_ADDR[OWN_AREA_W+:ID_W] == MY_ID
              && SLV_ADDR[OWN_AREA_W-1:0] == '0;
    end
  end

  // External DMA grant per channel, only when that channel is enabled.
  for (genvar c = 0; c < NUM_EXT_DMA; c++) begin : g_edma
    always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
        gnt_q[c] <= 1'b0;
      end else begin
        gnt_q[c] <= EXT_DMA_REQUEST[c] && DMA_EN[c] && !gnt_q[c];
      end
    end
  end
  assign EXT_DMA_GRANT = gnt_q;

  // Channel round robin over the four port channels.
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      dsel_q <= 2'h0;
      DMA_SERVED <= '0;
    end else begin
      dsel_q <= dsel_q + 2'h1;
      DMA_SERVED <= '0;
      if (DMA_EN[dsel_q]) begin
        DMA_SERVED[dsel_q] <= 1'b1;
      end
    end
  end

  // Halfword packer: builds 16, 32, 48 or 64-bit words.
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      pack_q <= '0;
      pcnt_q <= 2'h0;
      DMA_WORD <= '0;
      DMA_WORD_VALID <= 1'b0;
    end else begin
      DMA_WORD_VALID <= 1'b0;
      if (|DMA_SERVED) begin
        pack_q <= {EXT_DATA_IN[15:0], pack_q[DATA_W-1:16]};
        if (pcnt_q == PACK_MODE) begin
          DMA_WORD <= {EXT_DATA_IN[15:0], pack_q[DATA_W-1:16]}
                      >> (7'(3 - PACK_MODE) * 7'h10);
          DMA_WORD_VALID <= 1'b1;
          pcnt_q <= 2'h0;
        end else begin
          pcnt_q <= pcnt_q + 2'h1;
        end
      end
    end
  end

  // Lock never lets a host grant rise.
  property p_lock;
    @(posedge CLK_SYS) disable iff (!RSTN)
      lock_q && LOCK_REQ |=> !$rose(HOST_BUS_GRANT);
  endproperty
  AST_LOCK_HOLD: assert property (p_lock)
    else $error("host granted during lock");
  sequence s_arb_go;
    st_q == ST_ARB && acc_go;
  endsequence
  AST_HANDOVER: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      s_arb_go |=> BUS_OWNED)
    else $error("handover over one cycle");
  AST_WAITS: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      st_q == ST_ADDR && WAIT_STATES == 4'h2 |=> st_q == ST_WAIT [*3])
    else $error("wait states wrong");
  AST_ODD_LANE: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      BUS_OWNED && !cur_q.pair && !cur_q.fetch && cur_q.addr[0]
      |=> EXT_OUT.lane_en == 2'h2)
    else $error("odd word on wrong lane");
  AST_ONE_BANK: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      BUS_OWNED |-> $onehot(~BANK_SEL_N))
    else $error("bank select not one-hot");
  AST_HOST_GNT: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      HOST_BUS_GRANT |-> $past(HOST_BUS_REQUEST))
    else $error("host grant without request");
  AST_DMA_GNT: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      EXT_DMA_GRANT[0] |=> !EXT_DMA_GRANT[0])
    else $error("dma grant too long");
  AST_PACK32: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
      DMA_WORD_VALID && PACK_MODE == PACK_32 |-> DMA_WORD[63:32] == 32'h0)
    else $error("pack 32 wrong");
endmodule : sxp_port
`default_nettype wire

// file: verification/sxp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module sxp_mem_model (
  input wire logic clk,
  input wire sxp_pkg::sxp_ext_s ext,
  input wire logic slow,
  output logic ack,
  output logic [63:0] rd_data,
  output logic [63:0] wr_data,
  output logic [1:0] wr_lane
);
  import sxp_pkg::*;
  logic [2:0] stall_q = 3'h3;
  logic [63:0] junk_q = 64'h0;
  logic [31:0] base;
  // Word contents are the address scrambled by a fixed mask.
  assign base = {ext.addr[31:1], 1'b0};
  // The even word sits on the low lanes, the odd word on the high.
  assign rd_data = !ext.rd_n ?
    {(base | 32'h1) ^ 32'h5A5AC3C3, base ^ 32'h5A5AC3C3} : junk_q;
  // A slow part withholds acknowledge for three cycles per access.
  assign ack = !slow || stall_q == 3'h0 || (ext.rd_n && ext.wr_n);
  always_ff @(posedge clk) begin
    if (ext.rd_n && ext.wr_n) stall_q <= 3'h3;
    else if (stall_q != 3'h0) stall_q <= stall_q - 3'h1;
  end
  // Released data lines flip every cycle so stale values never match.
  always_ff @(posedge clk) junk_q <= ~junk_q;
  // Each write is captured together with the lanes it enabled.
  always_ff @(posedge clk) begin
    if (!ext.wr_n) begin
      wr_data <= ext.data;
      wr_lane <= ext.lane_en;
    end
  end
endmodule : sxp_mem_model
`default_nettype wire

// file: verification/sxp_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sxp_port_tb;
  import sxp_pkg::*;
  typedef struct packed {
    logic [1:0] k;
    logic [63:0] e;
    logic [63:0] m;
    logic [1:0] l;
  } sxp_note_s;
  logic clk, rstn, rot, lock, hreq, slv_w, slv_s, slow;
  logic hgnt, virq, bcast, imem, owned, ack, dwv;
  logic [1:0] acc, xdr, xdg, pk, wr_l, bsh;
  logic [3:0] ws, den, bsel_n, dsv;
  logic [5:0] peer;
  logic [2:0] done, seen;
  logic [31:0] slv_a, v;
  logic [31:0] seed = 32'h8F21;
  logic [63:0] rdata, xdin, wr_d, dw;
  logic [47:0] instr;
  sxp_req_s rq [3];
  sxp_ext_s ext;
  sxp_note_s nq [$];
  sxp_note_s nn;
  int bad_count = 0;
  int tests_run = 0;
  int j, nw;
  // The system clock runs at 10 MHz.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  sxp_port sxp_port_i (
    .CLK_SYS(clk), .RSTN(rstn), .PM_REQ(rq[0]), .DM_REQ(rq[1]),
    .IO_REQ(rq[2]), .ACC_TYPE(acc), .WAIT_STATES(ws), .BANK_SHIFT(bsh),
    .MY_ID(3'h2), .ROTATE_EN(rot), .LOCK_REQ(lock), .PEER_BUS_REQ(peer),
    .HOST_BUS_REQUEST(hreq), .HOST_CS(1'b0), .ACK_IN(ack),
    .EXT_DATA_IN(xdin), .SLV_ADDR(slv_a), .SLV_WRITE(slv_w),
    .SLV_STROBE(slv_s), .EXT_DMA_REQUEST(xdr), .DMA_EN(den),
    .PACK_MODE(pk), .REQ_DONE(done), .RDATA(rdata), .INSTR(instr),
    .EXT_OUT(ext), .EXT_DATA_OE(), .EXT_ADDR_OE(), .BANK_SEL_N(bsel_n),
    .BUS_REQ_OUT(), .BUS_OWNED(owned), .HOST_BUS_GRANT(hgnt),
    .HOST_ACCESS_READY(), .INT_MEM_SEL(imem), .VIRQ(virq),
    .BCAST_SEL(bcast), .EXT_DMA_GRANT(xdg), .DMA_SERVED(dsv),
    .DMA_WORD(dw), .DMA_WORD_VALID(dwv));
  sxp_mem_model sxp_mem_model_i (
    .clk(clk), .ext(ext), .slow(slow), .ack(ack), .rd_data(xdin),
    .wr_data(wr_d), .wr_lane(wr_l));
  function automatic logic [31:0] w(input logic [31:0] a);
    return a ^ 32'h5A5AC3C3;
  endfunction : w
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task err(input string s);
    bad_count++;
    $display("Error at %0t: %s", $time, s);
  endtask : err
  task chk(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) err("value mismatch");
  endtask : chk
  task give_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  // Kind 0 reads, 1 writes, 2 fetches; the note goes in before the request.
  task automatic op(input int s, input logic [1:0] k, input logic pr);
    sxp_note_s n;
    logic [31:0] a;
    logic [63:0] d, m;
    int i;
    a = rnd() | 32'h10000000;
    d = {rnd(), rnd()};
    if (pr || k == 2'h2) a[0] = 1'b0;
    if (!pr) d[63:32] = d[31:0];
    m = pr || k == 2'h2 ? '1 : a[0] ? {32'hFFFFFFFF, 32'h0} : 64'hFFFFFFFF;
    n = '{k, (k == 2'h1 ? d : {w(a | 32'h1), w(a)}) & m, m, {m[32], m[0]}};
    // A single odd word comes back right-aligned on the internal bus.
    if (k == 2'h0 && !pr && a[0]) n = '{k, {32'h0, w(a)}, 64'hFFFFFFFF, 2'h2};
    nq.push_back(n);
    @(posedge clk);
    rq[s] <= '{1'b1, k == 2'h1, k == 2'h2, pr || k == 2'h2, a, d};
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      #1;
      if (done[s] === 1'b1) break;
    end
    if (i == 300) err("request never completed");
    rq[s] <= '0;
  endtask : op
  // Each completion is matched against the oldest noted expectation.
  always @(posedge clk) begin
    if (owned === 1'b1 && (ext.rd_n === 1'b0 || ext.wr_n === 1'b0))
      chk(64'($countones(~bsel_n)), 64'h1);
    if (done != 3'h0 && nq.size() == 0) err("unexpected completion");
    else if (done != 3'h0) begin
      nn = nq.pop_front();
      if (nn.k == 2'h0) chk(rdata & nn.m, nn.e);
      else if (nn.k == 2'h2) chk(64'(instr), 64'(nn.e[47:0]));
      else begin
        chk(wr_d & nn.m, nn.e);
        chk(64'(wr_l), 64'(nn.l));
      end
    end
  end
  // A hang is cut short well after the tests should have ended.
  initial begin
    #3000000;
    err("watchdog expired");
    give_verdict();
  end
  // Main sequence of tests.
  initial begin
    rstn = 1'b0;
    {rot, lock, hreq, slv_w, slv_s, slow} = 6'h0;
    {acc, xdr, pk, bsh, ws, den, peer} = 22'h0;
    slv_a = 32'h0;
    for (j = 0; j < 3; j++) rq[j] = '0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (j = 0; j < 30; j++) begin
      @(posedge clk);
      v = rnd();
      acc <= 2'(v[1:0] % 2'h3);
      ws <= v[5:2];
      slow <= v[6];
      rot <= v[7];
      bsh <= v[9:8];
      op(int'(v[11:10] % 2'h3), 2'(v[13:12] % 2'h3), v[14]);
    end
    $display("Test of transfers finished");
    // A burst read keeps the bus and steps the address one pair per word.
    acc <= 2'(SXP_BURST);
    v = rnd();
    v[1:0] = 2'h0;
    for (j = 0; j < 2; j++)
      nq.push_back(sxp_note_s'{2'h0, {w(v + 32'(2 * j + 1)), w(v + 32'(2 * j))},
                               '1, 2'h3});
    @(posedge clk);
    rq[1] <= '{1'b1, 1'b0, 1'b0, 1'b1, v, 64'h0};
    seen = 3'h0;
    for (j = 0; j < 300 && seen != 3'h2; j++) begin
      @(posedge clk);
      #1;
      if (done[1] === 1'b1) seen = seen + 3'h1;
    end
    rq[1] <= '0;
    chk(64'(seen), 64'h2);
    $display("Test of burst read finished");
    rot <= 1'b0;
    peer <= 6'h01;
    fork
      op(1, 2'h0, 1'b1);
      begin
        repeat (10) @(posedge clk);
        chk(64'(owned), 64'h0);
        peer <= 6'h0;
      end
    join
    $display("Test of peer arbitration finished");
    // The lock is taken during our own access and then bars the host.
    lock <= 1'b1;
    op(1, 2'h0, 1'b0);
    hreq <= 1'b1;
    repeat (20) @(posedge clk);
    chk(64'(hgnt), 64'h0);
    lock <= 1'b0;
    for (j = 0; j < 20 && hgnt !== 1'b1; j++) @(posedge clk);
    chk(64'(hgnt), 64'h1);
    hreq <= 1'b0;
    repeat (4) @(posedge clk);
    $display("Test of lock and host grant finished");
    for (j = 0; j < 3; j++) begin
      @(posedge clk);
      slv_a <= {9'h0, j == 1 ? 3'h7 : 3'h2, j == 2 ? 20'h5 : 20'h0};
      slv_w <= 1'b1;
      slv_s <= 1'b1;
      @(posedge clk);
      slv_s <= 1'b0;
      seen = 3'h0;
      repeat (3) begin
        #1;
        seen = seen | {imem, bcast, virq};
        @(posedge clk);
      end
      chk(64'(seen[j]), 64'h1);
    end
    $display("Test of slave decode finished");
    den <= 4'hF;
    for (j = 0; j < 2; j++) begin
      @(posedge clk);
      xdr <= 2'h1 << j;
      pk <= 2'(j);
      seen = 3'h0;
      nw = 0;
      repeat (20) begin
        @(posedge clk);
        #1;
        seen = seen | {1'b0, xdg};
        nw = nw + int'(dwv);
        chk(64'($countones(dsv)), 64'h1);
      end
      xdr <= 2'h0;
      chk(64'(seen[j]), 64'h1);
      // Words keep coming and fill no more than their packed width.
      chk(64'(nw >= 20 / (j + 2)), 64'h1);
      chk(dw >> (16 * (j + 1)), 64'h0);
    end
    $display("Test of peripheral pacing finished");
    repeat (4) @(posedge clk);
    give_verdict();
  end
endmodule : sxp_port_tb
`default_nettype wire
